// >>> include/aptc_pkg.sv
// constants for the conversion-pair trigger control block
// assumes one 20 mhz clock and a 32-bit axi4-lite register port
package aptc_pkg;

	// clock rate of aclk
	localparam int unsigned CLK_HZ = 20000000;

	// number of conversion pairs handled here
	localparam int unsigned NUM_PAIRS = 3;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL_A = 8'h00; // pair a in low byte
	localparam logic [7:0] OFS_CTRL_B = 8'h04; // pair b low, pair c high
	localparam logic [7:0] OFS_GLOBAL = 8'h08; // global software trigger

	// field positions inside one pair byte, and of the bit in the global trigger register
	localparam int unsigned FLD_IRQ    = 7;
	localparam int unsigned FLD_PEND   = 6;
	localparam int unsigned FLD_SOFT   = 5;
	localparam int unsigned FLD_SEL_HI = 4;
	localparam int unsigned FLD_SEL_LO = 0;
	localparam int unsigned FLD_GLOBAL = 0;

	// reset values
	localparam logic [4:0] SEL_RESET = 5'h00;
	localparam logic       BIT_RESET = 1'b0;

	// trigger source selector codes
	localparam logic [4:0] SEL_OFF         = 5'h00;
	localparam logic [4:0] SEL_SOFT        = 5'h01;
	localparam logic [4:0] SEL_GLOBAL      = 5'h02;
	localparam logic [4:0] SEL_SPECIAL     = 5'h03;
	localparam logic [4:0] SEL_PRI_BASE    = 5'h04;
	localparam logic [4:0] SEL_TMR1        = 5'h0c;
	localparam logic [4:0] SEL_SEC_SPECIAL = 5'h0d;
	localparam logic [4:0] SEL_SEC_BASE    = 5'h0e;
	localparam logic [4:0] SEL_CLIM_BASE   = 5'h17;
	localparam logic [4:0] SEL_TMR2        = 5'h1f;

	// analog inputs served by each pair
	localparam logic [4:0] CHAN_HI [0:2] = '{5'h11, 5'h15, 5'h17};
	localparam logic [4:0] CHAN_LO [0:2] = '{5'h10, 5'h14, 5'h16};

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	// conversion sequencer states
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_REQ  = 2'b01,
		S_WAIT = 2'b10
	} aptc_state_e;

endpackage

// >>> logic/aptc_pair.sv
// one conversion pair: control fields, trigger decode, pending, irq
// assumes trigger sources come from logic on the same clock
`timescale 1ns/1ps
module aptc_pair (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// register write of this pair's byte
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_fields,
	// trigger sources, indexed by selector code
	input  wire logic        global_soft,
	input  wire logic [31:0] trig_src,
	// conversion of this pair finished
	input  wire logic        conv_done,
	// pair state
	output logic             irq_enable,
	output logic             pending,
	output logic             soft_trigger,
	output logic [4:0]       trigger_select,
	output logic             irq_pulse
);

	logic hit; // selected trigger asserted this cycle

	////////////////////////////////////////////////////////////////
	// trigger decode
	always_comb begin
		case (trigger_select)
			aptc_pkg::SEL_OFF: hit = 1'b0;
			aptc_pkg::SEL_SOFT: hit = soft_trigger;
			aptc_pkg::SEL_GLOBAL: hit = soft_trigger | global_soft;
			default: hit = trig_src[trigger_select];
		endcase
	end

	////////////////////////////////////////////////////////////////
	// software fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_enable     <= aptc_pkg::BIT_RESET;
			trigger_select <= aptc_pkg::SEL_RESET;
		end else if (wr_en) begin
			irq_enable     <= wr_fields[aptc_pkg::FLD_IRQ];
			trigger_select <= wr_fields[aptc_pkg::FLD_SEL_HI:aptc_pkg::FLD_SEL_LO];
		end
	end

	// software trigger, self clearing when pending is set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_trigger <= aptc_pkg::BIT_RESET;
		end else if (wr_en) begin
			soft_trigger <= wr_fields[aptc_pkg::FLD_SOFT];
		end else if (hit) begin
			soft_trigger <= 1'b0;
		end
	end

	// pending: a new trigger wins over completion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending <= aptc_pkg::BIT_RESET;
		end else if (hit) begin
			pending <= 1'b1;
		end else if (conv_done) begin
			pending <= 1'b0;
		end
	end

	// one-cycle interrupt request on completion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_pulse <= 1'b0;
		end else begin
			irq_pulse <= conv_done & irq_enable;
		end
	end

endmodule

// >>> logic/aptc_top.sv
// conversion-pair trigger control: axi4-lite registers, three pairs,
// and a sequencer that hands pending pairs to the shared converter
// assumes all trigger and converter signals share aclk
//
// Notes on behaviour
// - enabled pair pulses irq on completion
// - selected trigger sets pair pending bit
// - pending clears when pair conversion finishes
// - soft bit starts pair under software selector
// - soft bit clears as pending sets
// - selector zero disables the pair
// - codes one to three: soft, global, special
// - codes 4 to 11: pwm primary 1-8
// - code 12 timer one, 31 timer two
// - code 13 secondary special, 14-22 secondary
// - codes 23 to 30: current-limit 1-8
// - busy converter holds request until accepted
// - upper pair bits 15-8, lower 7-0
// - pairs convert inputs 17/16, 21/20, 23/22
`timescale 1ns/1ps
module aptc_top (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// trigger sources
	input  wire logic        pwm_special_trig,
	input  wire logic        pwm_sec_special_trig,
	input  wire logic [7:0]  pwm_primary_trig,
	input  wire logic [8:0]  pwm_secondary_trig,
	input  wire logic [7:0]  pwm_climit_trig,
	input  wire logic        timer1_match,
	input  wire logic        timer2_match,
	// shared converter
	output logic             conv_req,
	output logic [1:0]       conv_pair_index,
	output logic [4:0]       conv_chan_hi,
	output logic [4:0]       conv_chan_lo,
	input  wire logic        conv_ack,
	input  wire logic        conv_done,
	// interrupt requests, one per pair
	output logic [2:0]       irq_pair
);

	////////////////////////////////////////////////////////////////
	// declarations

	// write channel holding state
	logic        aw_hold;   // write address captured
	logic        w_hold;    // write data captured
	logic [7:0]  aw_addr;   // captured write address
	logic [31:0] w_data;    // captured write data
	logic [3:0]  w_strb;    // captured byte strobes
	logic        wr_commit; // both halves present, response free

	// write decode
	logic        wr_hit_a;   // write to pair a register
	logic        wr_hit_b;   // write to pair b/c register
	logic        wr_hit_g;   // write to global trigger register
	logic        global_soft; // one-cycle global software trigger

	// per-pair signals
	logic [2:0]  pair_wr;       // byte write strobe per pair
	logic [7:0]  pair_fields [0:2]; // written byte per pair
	logic [7:0]  pair_view [0:2];   // readable byte per pair
	logic [2:0]  pair_pend;     // pending bits
	logic [2:0]  pair_done;     // completion routed to a pair
	logic [2:0]  pair_irq_en;   // irq enables
	logic [2:0]  pair_soft;     // software trigger bits
	logic [4:0]  pair_sel [0:2]; // trigger selectors
	logic [31:0] trig_src;      // sources by selector code

	// read decode
	logic [31:0] next_rdata; // word for the read address
	logic [1:0]  next_rresp; // response for the read address

	// sequencer
	aptc_pkg::aptc_state_e state; // sequencer state
	logic [1:0]  active;    // pair being converted
	logic [1:0]  next_pick; // lowest pending pair
	logic        any_pend;  // at least one pair pending

	////////////////////////////////////////////////////////////////
	// trigger source vector, indexed by selector code

	always_comb begin
		trig_src = 32'h0000_0000;
		trig_src[aptc_pkg::SEL_SPECIAL] = pwm_special_trig;
		trig_src[aptc_pkg::SEL_PRI_BASE +: 8] = pwm_primary_trig;
		trig_src[aptc_pkg::SEL_TMR1] = timer1_match;
		trig_src[aptc_pkg::SEL_SEC_SPECIAL] = pwm_sec_special_trig;
		trig_src[aptc_pkg::SEL_SEC_BASE +: 9] = pwm_secondary_trig;
		trig_src[aptc_pkg::SEL_CLIM_BASE +: 8] = pwm_climit_trig;
		trig_src[aptc_pkg::SEL_TMR2] = timer2_match;
	end

	////////////////////////////////////////////////////////////////
	// axi write channel: address and data taken in either order

	// write address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold       <= 1'b0;
			aw_addr       <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			// response taken, reopen for next write
			aw_hold       <= 1'b0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			// address accepted, hold until response
			aw_hold       <= 1'b1;
			aw_addr       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (!aw_hold && !s_axi_bvalid) begin
			// ready after reset release
			s_axi_awready <= 1'b1;
		end
	end

	// write data capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			// response taken, reopen for next write
			w_hold       <= 1'b0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			// data accepted, hold until response
			w_hold       <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (!w_hold && !s_axi_bvalid) begin
			// ready after reset release
			s_axi_wready <= 1'b1;
		end
	end

	// commit when both halves are in and no response is waiting
	assign wr_commit = aw_hold && w_hold && !s_axi_bvalid;

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= aptc_pkg::RESP_OKAY;
		end else if (wr_commit) begin
			s_axi_bvalid <= 1'b1;
			if (wr_hit_a || wr_hit_b || wr_hit_g) begin
				s_axi_bresp <= aptc_pkg::RESP_OKAY;
			end else begin
				// unmapped word
				s_axi_bresp <= aptc_pkg::RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// write decode to pair bytes

	assign wr_hit_a = aw_addr[7:2] == aptc_pkg::OFS_CTRL_A[7:2];
	assign wr_hit_b = aw_addr[7:2] == aptc_pkg::OFS_CTRL_B[7:2];
	assign wr_hit_g = aw_addr[7:2] == aptc_pkg::OFS_GLOBAL[7:2];

	// global trigger strobe, write-one, never stored
	assign global_soft = wr_commit && wr_hit_g && w_strb[0]
		&& w_data[aptc_pkg::FLD_GLOBAL];

	// byte lanes: pair a low byte of a, b low and c high byte of b
	always_comb begin
		pair_wr[0]     = wr_commit && wr_hit_a && w_strb[0];
		pair_wr[1]     = wr_commit && wr_hit_b && w_strb[0];
		pair_wr[2]     = wr_commit && wr_hit_b && w_strb[1];
		pair_fields[0] = w_data[7:0];
		pair_fields[1] = w_data[7:0];
		pair_fields[2] = w_data[15:8];
	end

	////////////////////////////////////////////////////////////////
	// pair instances

	generate
		for (genvar i = 0; i < 3; i++) begin : g_pair
			aptc_pair u_pair (
				.aclk           (aclk),
				.aresetn        (aresetn),
				.wr_en          (pair_wr[i]),
				.wr_fields      (pair_fields[i]),
				.global_soft    (global_soft),
				.trig_src       (trig_src),
				.conv_done      (pair_done[i]),
				.irq_enable     (pair_irq_en[i]),
				.pending        (pair_pend[i]),
				.soft_trigger   (pair_soft[i]),
				.trigger_select (pair_sel[i]),
				.irq_pulse      (irq_pair[i])
			);
			// readable byte in field order
			assign pair_view[i] = {pair_irq_en[i], pair_pend[i],
				pair_soft[i], pair_sel[i]};
			// completion only counts for the pair in service
			assign pair_done[i] = conv_done && (state == aptc_pkg::S_WAIT)
				&& (active == 2'(i));
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// axi read channel

	// read decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rresp = aptc_pkg::RESP_OKAY;
		if (s_axi_araddr[7:2] == aptc_pkg::OFS_CTRL_A[7:2]) begin
			// upper byte of this word belongs to no pair here
			next_rdata[7:0] = pair_view[0];
		end else if (s_axi_araddr[7:2] == aptc_pkg::OFS_CTRL_B[7:2]) begin
			next_rdata[7:0]  = pair_view[1];
			next_rdata[15:8] = pair_view[2];
		end else if (s_axi_araddr[7:2] == aptc_pkg::OFS_GLOBAL[7:2]) begin
			// strobe register reads zero
			next_rdata = 32'h0000_0000;
		end else begin
			// unmapped word
			next_rresp = aptc_pkg::RESP_DECERR;
		end
	end

	// read address accept and data return
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= aptc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			// one read at a time
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			// ready after reset release
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// sequencer: lowest pending pair first

	// priority pick
	always_comb begin
		any_pend  = |pair_pend;
		next_pick = 2'd0;
		for (int k = 2; k >= 0; k--) begin
			if (pair_pend[k]) begin
				next_pick = 2'(k);
			end
		end
	end

	// state and request handshake with the converter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state           <= aptc_pkg::S_IDLE;
			active          <= 2'd0;
			conv_req        <= 1'b0;
			conv_pair_index <= 2'd0;
			conv_chan_hi    <= 5'h00;
			conv_chan_lo    <= 5'h00;
		end else begin
			case (state)
				aptc_pkg::S_IDLE: begin
					if (any_pend) begin
						// load the pair's fixed inputs
						active          <= next_pick;
						conv_req        <= 1'b1;
						conv_pair_index <= next_pick;
						conv_chan_hi    <= aptc_pkg::CHAN_HI[next_pick];
						conv_chan_lo    <= aptc_pkg::CHAN_LO[next_pick];
						state           <= aptc_pkg::S_REQ;
					end
				end
				aptc_pkg::S_REQ: begin
					// request stands while the converter is busy
					if (conv_ack) begin
						conv_req <= 1'b0;
						state    <= aptc_pkg::S_WAIT;
					end
				end
				aptc_pkg::S_WAIT: begin
					// pending of the active pair clears on this edge
					if (conv_done) begin
						state <= aptc_pkg::S_IDLE;
					end
				end
				default: begin
					state    <= aptc_pkg::S_IDLE;
					conv_req <= 1'b0;
				end
			endcase
		end
	end

endmodule

// >>> test/aptc_conv_model.sv
// shared converter model: accepts one pair, finishes after a delay
// assumes requests held until ack; stall withholds acceptance
`timescale 1ns/1ps
module aptc_conv_model #(
	parameter int LAT = 3 // finish comes LAT+2 cycles after accept
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request side
	input wire logic conv_req,
	input wire logic stall,
	output logic     conv_ack,
	output logic     conv_done
);
	logic       busy; // conversion under way
	logic [3:0] cnt;  // cycles since accept
	// accept, count, finish; done never sooner than a cycle after ack
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_ack <= 1'b0;
			conv_done <= 1'b0;
			busy <= 1'b0;
			cnt <= 4'h0;
		end else begin
			conv_ack <= conv_req && !conv_ack && !busy && !stall;
			conv_done <= busy && cnt == 4'(LAT);
			if (conv_ack) begin
				busy <= 1'b1;
				cnt <= 4'h0;
			end else if (busy) begin
				cnt <= cnt + 4'h1;
				busy <= cnt != 4'(LAT);
			end
		end
	end
endmodule

// >>> test/aptc_top_bench.sv
// self-checking bench for the conversion-pair trigger control
// assumes the converter model and the bound checker
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module aptc_top_bench;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, stall = 1, awready, wready, bvalid;
	logic        arready, rvalid, req, ack, done;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0]  wstrb = 4'hf;
	logic [1:0]  bresp, rresp, pidx;
	logic [28:0] trg = 0;  // all trigger sources
	logic [4:0]  chi, clo;
	logic [2:0]  irq;
	logic [1:0]  served[$]; // pairs in order of acceptance
	int          failures = 0, samples_checked = 0, irq_cnt = 0, done_cnt = 0;
	integer      seed = 32'h1579d6ab;
	always #25 aclk = ~aclk;
	aptc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_special_trig(trg[0]),
		.pwm_sec_special_trig(trg[9]), .pwm_primary_trig(trg[8:1]),
		.pwm_secondary_trig(trg[18:10]), .pwm_climit_trig(trg[26:19]),
		.timer1_match(trg[28]), .timer2_match(trg[27]), .conv_req(req),
		.conv_pair_index(pidx), .conv_chan_hi(chi), .conv_chan_lo(clo), .conv_ack(ack),
		.conv_done(done), .irq_pair(irq));
	aptc_conv_model conv (.aclk(aclk), .aresetn(aresetn), .conv_req(req), .stall(stall),
		.conv_ack(ack), .conv_done(done));
	////////////////////////////////////////////////////////////////////
	// log accepts, completions and pair a interrupts
	always @(posedge aclk) begin
		if (req && ack) served.push_back(pidx);
		if (done) done_cnt++;
		if (irq[0]) irq_cnt++;
	end
	// trigger bit for a selector code
	function automatic int sel_bit(input int c);
		if (c < 12) return c - 3;
		if (c == 12) return 28;
		if (c == 13) return 9;
		if (c == 31) return 27;
		return c - 4;
	endfunction
	// bus write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw, w;
		aw = 1;
		w = 1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && awready) begin
				aw = 0;
				awvalid <= 0;
			end
			if (w && wready) begin
				w = 0;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 0;
		`CHK("bresp", e, bresp)
		// let bready low pass an edge before the next write raises it
		@(posedge aclk);
	endtask
	// bus read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		rready <= 0;
		`CHK("rdata", e, rdata)
		`CHK("rresp", er, rresp)
		// let rready low pass an edge before the next read raises it
		@(posedge aclk);
	endtask
	// one-cycle trigger, all sources when b is negative
	task automatic pulse(input int b);
		if (b < 0) trg <= '1;
		else trg[b] <= 1;
		@(posedge aclk);
		trg <= '0;
		@(posedge aclk);
	endtask
	// let the converter finish k pairs
	task automatic drain(input int k);
		int n;
		n = done_cnt;
		stall <= 0;
		for (int i = 0; i < 200 && done_cnt < n + k; i++) @(posedge aclk);
		repeat (2) @(posedge aclk);
		stall <= 1;
	endtask
	task automatic close_out;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		close_out();
	end
	// main sequence
	initial begin
		int b, o, n;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		rd(8'h00, 0, 2'b00);
		rd(8'h04, 0, 2'b00);
		rd(8'h08, 0, 2'b00);
		rd(8'h0c, 0, 2'b11);
		wr(8'h0c, 32'hff, 2'b11);
		for (int c = 3; c < 32; c++) begin
			wr(8'h00, {24'h0, 3'b100, 5'(c)}, 2'b00);
			b = sel_bit(c);
			o = $unsigned($random(seed)) % 28;
			if (o >= b) o++;
			pulse(o);
			rd(8'h00, {24'h0, 3'b100, 5'(c)}, 2'b00);
			pulse(b);
			rd(8'h00, {24'h0, 3'b110, 5'(c)}, 2'b00);
			n = irq_cnt;
			drain(1);
			`CHK("irq", n + 1, irq_cnt)
			rd(8'h00, {24'h0, 3'b100, 5'(c)}, 2'b00);
		end
		n = irq_cnt;
		wr(8'h00, 32'h23, 2'b00);
		rd(8'h00, 32'h23, 2'b00);
		wr(8'h00, 32'h21, 2'b00);
		rd(8'h00, 32'h41, 2'b00);
		drain(1);
		wr(8'h00, 32'h02, 2'b00);
		wr(8'h08, 32'h01, 2'b00);
		rd(8'h00, 32'h42, 2'b00);
		drain(1);
		wr(8'h00, 32'h22, 2'b00);
		rd(8'h00, 32'h42, 2'b00);
		drain(1);
		wr(8'h00, 32'h20, 2'b00);
		pulse(-1);
		rd(8'h00, 32'h20, 2'b00);
		wr(8'h04, 32'h1234_6d4c, 2'b00);
		rd(8'h04, 32'h0000_2d0c, 2'b00);
		wstrb <= 4'h2;
		wr(8'h04, 32'h0000_0100, 2'b00);
		wstrb <= 4'hf;
		rd(8'h04, 32'h0000_010c, 2'b00);
		wr(8'h00, 32'h21, 2'b00);
		wr(8'h04, 32'h0000_2121, 2'b00);
		rd(8'h04, 32'h0000_4141, 2'b00);
		served.delete();
		drain(3);
		`CHK("order", 6'b00_01_10, {served[0], served[1], served[2]})
		`CHK("irq", n, irq_cnt)
		rd(8'h04, 32'h0000_0101, 2'b00);
		close_out();
	end
endmodule

// >>> test/aptc_top_properties.sv
// checker for the conversion-pair trigger control top ports
// assumes binding to aptc_top, one clock aclk, reset aresetn
`timescale 1ns/1ps
module aptc_top_properties (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// bus responses
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	// converter side
	input wire logic       conv_req,
	input wire logic [1:0] conv_pair_index,
	input wire logic [4:0] conv_chan_hi,
	input wire logic [4:0] conv_chan_lo,
	input wire logic       conv_ack,
	input wire logic       conv_done,
	input wire logic [2:0] irq_pair
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////
	// request offered, not yet taken
	sequence req_waiting;
		conv_req && !conv_ack;
	endsequence
	// request taken by the converter
	sequence req_taken;
		conv_req && conv_ack;
	endsequence
	////////////////////////////////////////////////////////////////////
	req_hold_a: assert property (req_waiting |=> conv_req && $stable(conv_pair_index))
		else $error("request dropped before accept");
	req_drop_a: assert property (req_taken |=> !conv_req)
		else $error("request kept after accept");
	chan_map_a: assert property (conv_req |-> conv_pair_index != 2'h3 &&
		conv_chan_hi == (conv_pair_index == 2'h0 ? 5'h11 :
		conv_pair_index == 2'h1 ? 5'h15 : 5'h17) && conv_chan_lo == conv_chan_hi - 5'h01)
		else $error("wrong channels for pair");
	irq_cause_a: assert property (irq_pair != 3'h0 |-> $past(conv_done))
		else $error("irq without completion");
	irq_single_a: assert property (irq_pair != 3'h0 |=> irq_pair == 3'h0)
		else $error("irq longer than one cycle");
	irq_pair_a: assert property (irq_pair != 3'h0 |-> irq_pair == 3'h1 << $past(conv_pair_index))
		else $error("irq on wrong pair");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped");
endmodule
bind aptc_top aptc_top_properties chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.conv_req(conv_req), .conv_pair_index(conv_pair_index), .conv_chan_hi(conv_chan_hi),
	.conv_chan_lo(conv_chan_lo), .conv_ack(conv_ack), .conv_done(conv_done),
	.irq_pair(irq_pair));
